/* File: common/smio_pkg.sv */
package smio_pkg;

  // lane width of the current command, one-hot
  typedef enum logic [2:0] {
    SMIO_SINGLE = 3'h1,
    SMIO_DUAL = 3'h2,
    SMIO_QUAD = 3'h4
  } smio_mode_e;

  localparam int SMIO_BYTE_W = 8;
  localparam int SMIO_FIFO_DEPTH = 16;
  localparam int SMIO_LANES = 4;
  localparam logic [3:0] SMIO_BITS_SINGLE = 4'h1;
  localparam logic [3:0] SMIO_BITS_DUAL = 4'h2;
  localparam logic [3:0] SMIO_BITS_QUAD = 4'h4;
  localparam logic [3:0] SMIO_BITS_BYTE = 4'h8;
  localparam logic [3:0] SMIO_MASK_SINGLE = 4'h2;
  localparam logic [3:0] SMIO_MASK_DUAL = 4'h3;
  localparam logic [3:0] SMIO_MASK_QUAD = 4'hF;
  // byte sent when the user has nothing queued
  localparam logic [7:0] SMIO_FILL_BYTE = 8'hFF;
  localparam int SMIO_SYNC_STAGES = 3;

endpackage

/* File: hdl/smio_pins.sv */
////////////////////////////////////////////////////////////////////////////////
// plain flop fifo, valid/ready on both sides
module smio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != FULL_CNT);
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_idx];

  // storage is written only, never reset, to keep it cheap
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_idx] <= in_data;
    end
  end

  // pointers wrap at depth, so depth need not be a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// multi-lane serial pin interface of the memory, device side
module smio_pins
  import smio_pkg::*;
#(
  parameter int FIFO_DEPTH = SMIO_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic data_line_0_in,
  output logic data_line_0_out,
  output logic data_line_0_oe,
  input wire logic data_line_1_in,
  output logic data_line_1_out,
  output logic data_line_1_oe,
  input wire logic data_line_2_in,
  output logic data_line_2_out,
  output logic data_line_2_oe,
  input wire logic data_line_3_in,
  output logic data_line_3_out,
  output logic data_line_3_oe,
  input wire logic do_not_use_test_pin,
  input wire logic [2:0] io_mode,
  input wire logic drive_out,
  input wire logic quad_enable,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_drop,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic write_protect_n,
  output logic test_active
);
  logic armed;
  logic link_rst_n;
  logic [2:0] mode_s1, mode_s2;
  logic drv_s1, drv_s2, qe_s1, qe_s2;
  logic req_s1, req_s2;
  logic paused_q, paused, hold_en, pause_live;
  logic [3:0] nbits, lane_mask, lane_in, lane_out, lane_oe_bus;
  logic [7:0] rx_shift, rx_next, rx_byte;
  logic [3:0] rx_cnt, tx_cnt;
  logic rx_tgl, ack_tgl;
  logic [7:0] tx_shift, tx_hold;
  logic tx_req, drive_q;
  logic [SMIO_SYNC_STAGES-1:0] rx_sync, ack_sync, wp_sync, tst_sync;
  logic rx_acc, ack_acc, wp_acc, tst_acc;
  logic rx_event, fifo_in_ready;

  //////////////////////////////////////////////////////////////////////////////
  // link domain

  // a select falling edge must be seen once after power-up
  always_ff @(negedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else begin
      armed <= 1'b1;
    end
  end

  // deselect clears the link logic at once; select is active low
  assign link_rst_n = rst_n & armed & ~cs_n;

  // controls are quasi-static; the clock stops between frames, so the
  // synchronisers keep last frame's value rather than resetting per frame
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1 <= SMIO_SINGLE;
      mode_s2 <= SMIO_SINGLE;
      drv_s1 <= 1'b0;
      drv_s2 <= 1'b0;
      qe_s1 <= 1'b0;
      qe_s2 <= 1'b0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else begin
      mode_s1 <= io_mode;
      mode_s2 <= mode_s1;
      drv_s1 <= drive_out;
      drv_s2 <= drv_s1;
      qe_s1 <= quad_enable;
      qe_s2 <= qe_s1;
      req_s1 <= tx_req;
      req_s2 <= req_s1;
    end
  end

  // lane count and lanes the device may drive for each width
  always_comb begin
    case (mode_s2)
      SMIO_DUAL: begin
        nbits = SMIO_BITS_DUAL;
        lane_mask = SMIO_MASK_DUAL;
      end
      SMIO_QUAD: begin
        nbits = SMIO_BITS_QUAD;
        lane_mask = qe_s2 ? SMIO_MASK_QUAD : SMIO_MASK_DUAL;
      end
      default: begin
        nbits = SMIO_BITS_SINGLE;
        lane_mask = SMIO_MASK_SINGLE;
      end
    endcase
  end

  // pause pin is the fourth line unless quad enable claims it
  assign hold_en = ~qe_s2;

  // pin level seen during the low phase decides each rising edge; the value
  // at the rise is held through the high phase, so a high-phase change waits
  assign pause_live = hold_en & ~data_line_3_in;
  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      paused_q <= 1'b0;
    end else begin
      paused_q <= pause_live;
    end
  end
  assign paused = sck ? paused_q : pause_live;

  assign lane_in = {data_line_3_in, data_line_2_in, data_line_1_in, data_line_0_in};

  // shift in msb first by the active width
  always_comb begin
    case (mode_s2)
      SMIO_DUAL: rx_next = {rx_shift[5:0], lane_in[1:0]};
      SMIO_QUAD: rx_next = {rx_shift[3:0], lane_in};
      default: rx_next = {rx_shift[6:0], lane_in[0]};
    endcase
  end

  // capture on the rising clock, only while the host owns the lines
  always_ff @(posedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_shift <= '0;
      rx_cnt <= '0;
    end else if (!pause_live && !drv_s2) begin
      rx_shift <= rx_next;
      rx_cnt <= (rx_cnt + nbits == SMIO_BITS_BYTE) ? '0 : rx_cnt + nbits;
    end
  end

  // byte and toggle survive deselect so the last byte still crosses
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= '0;
      rx_tgl <= 1'b0;
    end else if (link_rst_n && !pause_live && !drv_s2 &&
                 (rx_cnt + nbits == SMIO_BITS_BYTE)) begin
      rx_byte <= rx_next;
      rx_tgl <= ~rx_tgl;
    end
  end

  // launch on the falling clock; a byte starts when the count is zero
  always_ff @(negedge sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_shift <= SMIO_FILL_BYTE;
      tx_cnt <= '0;
      drive_q <= 1'b0;
    end else if (!paused) begin
      drive_q <= drv_s2;
      if (drv_s2) begin
        if (tx_cnt == '0) begin
          tx_shift <= (req_s2 != ack_tgl) ? tx_hold : SMIO_FILL_BYTE;
        end else begin
          tx_shift <= tx_shift << nbits;
        end
        tx_cnt <= (tx_cnt + nbits == SMIO_BITS_BYTE) ? '0 : tx_cnt + nbits;
      end
    end
  end

  // acknowledge kept outside frame reset, the toggle must not rewind
  always_ff @(negedge sck or negedge rst_n) begin
    if (!rst_n) begin
      ack_tgl <= 1'b0;
    end else if (link_rst_n && !paused && drv_s2 && tx_cnt == '0 &&
                 req_s2 != ack_tgl) begin
      ack_tgl <= ~ack_tgl;
    end
  end

  // top bits of the shifter onto the lanes of the active width
  always_comb begin
    case (mode_s2)
      SMIO_DUAL: lane_out = {2'b00, tx_shift[7:6]};
      SMIO_QUAD: lane_out = tx_shift[7:4];
      default: lane_out = {2'b00, tx_shift[7], 1'b0};
    endcase
  end

  // enables drop at once on deselect or pause
  genvar g;
  for (g = 0; g < SMIO_LANES; g++) begin : g_lane
    assign lane_oe_bus[g] = drive_q & lane_mask[g] & ~paused & link_rst_n;
  end
  assign data_line_0_out = lane_out[0];
  assign data_line_1_out = lane_out[1];
  assign data_line_2_out = lane_out[2];
  assign data_line_3_out = lane_out[3];
  assign data_line_0_oe = lane_oe_bus[0];
  assign data_line_1_oe = lane_oe_bus[1];
  assign data_line_2_oe = lane_oe_bus[2];
  assign data_line_3_oe = lane_oe_bus[3];

  //////////////////////////////////////////////////////////////////////////////
  // system domain

  // three-stage synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sync <= '0;
      ack_sync <= '0;
      wp_sync <= '1;
      tst_sync <= '0;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_tgl};
      ack_sync <= {ack_sync[1:0], ack_tgl};
      wp_sync <= {wp_sync[1:0], data_line_2_in};
      tst_sync <= {tst_sync[1:0], do_not_use_test_pin};
    end
  end

  // a change is accepted once stages 1 and 2 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_acc <= 1'b0;
      ack_acc <= 1'b0;
      wp_acc <= 1'b1;
      tst_acc <= 1'b0;
    end else begin
      if (rx_sync[1] == rx_sync[2]) rx_acc <= rx_sync[2];
      if (ack_sync[1] == ack_sync[2]) ack_acc <= ack_sync[2];
      if (wp_sync[1] == wp_sync[2]) wp_acc <= wp_sync[2];
      if (tst_sync[1] == tst_sync[2]) tst_acc <= tst_sync[2];
    end
  end

  assign rx_event = (rx_sync[1] == rx_sync[2]) && (rx_sync[2] != rx_acc);

  // the link cannot be stalled, so a full fifo drops and reports it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_drop <= 1'b0;
    end else begin
      rx_drop <= rx_event & ~fifo_in_ready;
    end
  end

  smio_fifo #(
    .WIDTH(SMIO_BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(rx_byte),
    .in_valid(rx_event),
    .in_ready(fifo_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // one byte in flight; hold is stable until the link acknowledges
  assign tx_ready = (tx_req == ack_acc);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_req <= 1'b0;
      tx_hold <= SMIO_FILL_BYTE;
    end else if (tx_valid && tx_ready) begin
      tx_req <= ~tx_req;
      tx_hold <= tx_data;
    end
  end

  // protect is active low and vanishes under quad enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_protect_n <= 1'b1;
      test_active <= 1'b0;
    end else begin
      write_protect_n <= quad_enable | wp_acc;
      test_active <= tst_acc;
    end
  end
endmodule

/* File: bench/smio_pins_props.sv */
module smio_pins_props
  import smio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic data_line_2_in,
  input wire logic data_line_0_out,
  input wire logic data_line_1_out,
  input wire logic data_line_2_out,
  input wire logic data_line_3_out,
  input wire logic data_line_0_oe,
  input wire logic data_line_1_oe,
  input wire logic data_line_2_oe,
  input wire logic data_line_3_oe,
  input wire logic do_not_use_test_pin,
  input wire logic [2:0] io_mode,
  input wire logic drive_out,
  input wire logic quad_enable,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic rx_drop,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic write_protect_n,
  input wire logic test_active
);
  logic [3:0] oe;
  logic [3:0] outs;
  // gathered lanes; controls are synced, so waits of 8 cycles
  assign oe = {data_line_3_oe, data_line_2_oe, data_line_1_oe, data_line_0_oe};
  assign outs = {data_line_3_out, data_line_2_out, data_line_1_out, data_line_0_out};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_desel_float: assert property (cs_n |-> oe == 4'h0)
    else $error("lane driven while deselected");
  a_out_launch: assert property (sck && $past(sck) && !cs_n && !$past(cs_n) |-> $stable(outs))
    else $error("output moved while clock high");
  a_idle_no_drive: assert property (!drive_out [*8] |-> oe == 4'h0)
    else $error("lane driven without read");
  a_single_line0: assert property ((io_mode == SMIO_SINGLE) [*8] |-> !data_line_0_oe)
    else $error("line 0 driven in single width");
  a_upper_lanes: assert property (!quad_enable [*8] |-> !(data_line_2_oe || data_line_3_oe))
    else $error("upper lane driven without quad enable");
  a_qe_wp_off: assert property (quad_enable [*8] |-> write_protect_n)
    else $error("protect active under quad enable");
  a_wp_low: assert property ((!quad_enable && !data_line_2_in) [*8] |-> !write_protect_n)
    else $error("protect not taken from low pin");
  a_test_idle: assert property (!do_not_use_test_pin [*8] |-> !test_active)
    else $error("test function active with pin low");
  a_drop_pulse: assert property (rx_drop |-> rx_valid ##1 !rx_drop)
    else $error("drop not a single pulse at full");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("receive head changed unread");
  a_tx_taken: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("send byte not taken");
  c_drop: cover property (rx_drop);
  c_quad_out: cover property (data_line_3_oe);
  c_tx: cover property (tx_valid && tx_ready);
endmodule

bind smio_pins smio_pins_props u_props (.*);

/* File: bench/smio_host.sv */
module smio_host (
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] dev_out,
  output logic sck,
  output logic cs_n,
  output logic [3:0] lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] hd = 4'hF;
  logic [3:0] ho = 4'h0;
  logic flip = 1'b0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  // wire level: lines 2 and 3 pull up, loose 0 and 1 keep toggling
  always_comb begin
    for (int i = 0; i < 4; i++)
      lvl[i] = dev_oe[i] ? dev_out[i] : ho[i] ? hd[i] : i > 1 ? 1'b1 : flip ^ i[0];
  end
  always @(negedge sck) flip <= ~flip;
  task pulse();
    #7.5 sck = 1'b1;
    #7.5 sck = 1'b0;
  endtask
  // mode 0; deselected clocks let the device settle its synced controls
  task open(input bit rd);
    repeat (2) pulse();
    #5 cs_n = 1'b0;
    if (rd) pulse();
  endtask
  task close();
    #5 ho = 4'h0;
    cs_n = 1'b1;
    #10;
  endtask
  // one byte, msb first over w lanes; drive while clock low, sample on rise
  task xfer(input int w, input bit rd, input logic [7:0] b, output logic [7:0] r);
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    r = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      hd = 4'(b >> (8 - w)) | (w < 4 ? 4'hC : 4'h0);
      ho = rd ? 4'h0 : m;
      b = b << w;
      #7.5 sck = 1'b1;
      r = (r << w) | 8'(w == 1 ? {3'h0, lvl[1]} : lvl & m);
      #7.5 sck = 1'b0;
    end
  endtask
endmodule

/* File: bench/smio_pins_tb_top.sv */
module smio_pins_tb_top
  import smio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] io_mode = SMIO_SINGLE;
  logic drive_out = 1'b0;
  logic quad_enable = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic test_pin = 1'b0;
  logic [7:0] rx_data;
  logic rx_valid, rx_drop, tx_ready, write_protect_n, test_active, sck, cs_n;
  logic [3:0] oe, dout, lvl;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int drops = 0;
  always #2.5 clk = ~clk;
  smio_pins #(.FIFO_DEPTH(16)) uut (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .data_line_0_in(lvl[0]), .data_line_0_out(dout[0]), .data_line_0_oe(oe[0]),
    .data_line_1_in(lvl[1]), .data_line_1_out(dout[1]), .data_line_1_oe(oe[1]),
    .data_line_2_in(lvl[2]), .data_line_2_out(dout[2]), .data_line_2_oe(oe[2]),
    .data_line_3_in(lvl[3]), .data_line_3_out(dout[3]), .data_line_3_oe(oe[3]),
    .do_not_use_test_pin(test_pin), .io_mode(io_mode), .drive_out(drive_out),
    .quad_enable(quad_enable), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_drop(rx_drop), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .write_protect_n(write_protect_n), .test_active(test_active)
  );
  smio_host host (.dev_oe(oe), .dev_out(dout), .sck(sck), .cs_n(cs_n), .lvl(lvl));
  task final_report();
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // drop pulses counted, and a hang cut short well past the expected run
  always @(posedge clk) begin
    drops <= drops + int'(rx_drop);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task cfg(input logic [2:0] m, input logic d, input logic q);
    @(negedge clk);
    io_mode = m;
    drive_out = d;
    quad_enable = q;
  endtask
  task pop(input logic [7:0] exp);
    int t;
    t = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && t < 60) begin
      @(negedge clk);
      t++;
    end
    chk(rx_data, exp);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  task push(input logic [7:0] b);
    @(negedge clk);
    tx_data = b;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  // one received byte in each width, quad with the upper pins as data
  task t_rx();
    logic [7:0] r;
    for (int i = 0; i < 3; i++) begin
      cfg(3'(1 << i), 1'b0, i == 2);
      host.open(0);
      host.xfer(1 << i, 0, 8'hA5 ^ 8'(i), r);
      host.close();
      pop(8'hA5 ^ 8'(i));
    end
  endtask
  // queued byte, then the fill byte once nothing is queued
  task t_tx();
    logic [7:0] r;
    for (int i = 0; i < 3; i++) begin
      cfg(3'(1 << i), 1'b1, i == 2);
      push(8'h3C + 8'(i));
      host.open(1);
      host.xfer(1 << i, 1, 8'h00, r);
      chk(r, 8'h3C + 8'(i));
      host.xfer(1 << i, 1, 8'h00, r);
      chk(r, SMIO_FILL_BYTE);
      host.close();
    end
  endtask
  // overrun an unread buffer by one byte, then drain it dry
  task t_fifo();
    logic [7:0] r;
    cfg(SMIO_SINGLE, 1'b0, 1'b0);
    host.open(0);
    for (int i = 0; i < 17; i++) host.xfer(1, 0, 8'(i), r);
    host.close();
    repeat (10) @(negedge clk);
    chk(8'(drops), 8'h01);
    for (int i = 0; i < 16; i++) pop(8'(i));
    chk({7'h0, rx_valid}, 8'h00);
  endtask
  // clocks given while paused between two bytes must not shift anything in
  task t_pause();
    logic [7:0] r;
    cfg(SMIO_SINGLE, 1'b0, 1'b0);
    host.open(0);
    host.xfer(1, 0, 8'h5A, r);
    host.hd[3] = 1'b0;
    host.ho[3] = 1'b1;
    repeat (3) host.pulse();
    host.ho[3] = 1'b0;
    host.xfer(1, 0, 8'hC3, r);
    host.close();
    pop(8'h5A);
    pop(8'hC3);
  endtask
  // protect pin low, test strap high, then quad enable overrides protect
  task t_pins();
    cfg(SMIO_SINGLE, 1'b0, 1'b0);
    host.hd[2] = 1'b0;
    host.ho[2] = 1'b1;
    test_pin = 1'b1;
    repeat (10) @(negedge clk);
    chk({6'h0, write_protect_n, test_active}, 8'h01);
    quad_enable = 1'b1;
    repeat (10) @(negedge clk);
    chk({6'h0, write_protect_n, test_active}, 8'h03);
    test_pin = 1'b0;
    host.ho[2] = 1'b0;
    repeat (10) @(negedge clk);
    chk({6'h0, write_protect_n, test_active}, 8'h02);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_rx();
    t_tx();
    t_fifo();
    t_pause();
    t_pins();
    final_report();
  end
endmodule
